// ==== logic/pdss_top.sv ====
// Power-down pin handling, power-on reset gating and start-up strap capture
`timescale 1ns/1ps
`default_nettype none

module pdss_top #(
	parameter int STARTUP_LEN = pdss_pkg::STARTUP_CYCLES
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// Power-down pin and analog monitors
	input wire logic power_down_n,
	input wire pdss_pkg::pdss_por_t por_in,
	// Start-up straps
	input wire logic interface_select_strap,
	input wire logic page_select_strap_a,
	input wire logic page_select_strap_b,
	// Overlay and soft reset controls
	input wire logic overlay_valid,
	input wire logic soft_reset,
	// Status outputs
	output logic device_reset_n,
	output logic serial_enable,
	output logic calibrate,
	output logic running,
	output pdss_pkg::pdss_cfg_t cfg
);
	import pdss_pkg::*;

	typedef struct packed {
		logic [1:0] pd_sync;
		logic [1:0] strap_a_sync;
		logic [1:0] strap_b_sync;
		logic [1:0] iface_sync;
		logic [1:0] okc_sync;
		logic [1:0] okp_sync;
		logic pd_filt;
		logic [PD_CNT_W-1:0] low_cnt;
		pdss_state_t state;
		logic [STARTUP_CNT_W-1:0] st_cnt;
		pdss_cfg_t cfg;
		logic dev_rst_n;
		logic ser_en;
		logic cal;
		logic run;
	} pdss_regs_t;

	localparam logic [PD_CNT_W-1:0] PD_LIMIT = PD_CNT_W'(MIN_PD_CYCLES);
	localparam logic [STARTUP_CNT_W-1:0] ST_LAST =
		STARTUP_CNT_W'(STARTUP_LEN - 1);

	// Power-on contents: pin seen low, so the block starts powered down
	localparam pdss_regs_t RESET_REGS = '{
		pd_sync: 2'h0,
		strap_a_sync: 2'h0,
		strap_b_sync: 2'h0,
		iface_sync: 2'h0,
		okc_sync: 2'h0,
		okp_sync: 2'h0,
		pd_filt: 1'h0,
		low_cnt: '0,
		state: PDSS_OFF,
		st_cnt: '0,
		cfg: '0,
		dev_rst_n: 1'h0,
		ser_en: 1'h0,
		cal: 1'h0,
		run: 1'h0
	};

	// Shared entry into the calibration interval, from power-on or soft reset
	function automatic pdss_regs_t enter_startup(input pdss_regs_t r);
		pdss_regs_t n;
		n = r;
		n.st_cnt = '0;
		n.cal = 1'h1;
		n.run = 1'h0;
		n.state = PDSS_START;
		return n;
	endfunction : enter_startup

	// Common fall-back to reset; a pending calibration pulse is dropped too
	function automatic pdss_regs_t hold_reset(input pdss_regs_t r,
		input pdss_state_t next_state);
		pdss_regs_t n;
		n = r;
		n.state = next_state;
		n.dev_rst_n = 1'h0;
		n.run = 1'h0;
		n.cal = 1'h0;
		return n;
	endfunction : hold_reset

	// Page code from the straps; a programmed overlay wins over fixed pages
	function automatic logic [2:0] strap_page(input logic use_overlay,
		input logic sel_b, input logic sel_a);
		logic [2:0] page;
		if (use_overlay) begin
			page = PAGE_OVERLAY;
		end else begin
			page = {1'h0, sel_b, sel_a};
		end
		return page;
	endfunction : strap_page

	logic [1:0] rst_sync_q;
	logic rst_n;
	pdss_regs_t r_q;
	pdss_regs_t r_d;
	logic por_ok;

	// Reset release through two flip-flops
	// Release is synchronous so every state flop leaves reset together
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'h1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// Next-state logic for the whole block
	always_comb begin
		r_d = r_q;
		// Pins cross two flops; only stage one of each is read by stage two
		// Straps and monitors are pin levels too and get the same treatment
		r_d.pd_sync = {r_q.pd_sync[0], power_down_n};
		r_d.strap_a_sync = {r_q.strap_a_sync[0], page_select_strap_a};
		r_d.strap_b_sync = {r_q.strap_b_sync[0], page_select_strap_b};
		r_d.iface_sync = {r_q.iface_sync[0], interface_select_strap};
		r_d.okc_sync = {r_q.okc_sync[0], por_in.core_supply_ok};
		r_d.okp_sync = {r_q.okp_sync[0], por_in.pd_above_vih};
		// Low must persist for the full window; shorter glitches are dropped
		// Counting after the synchroniser costs only two cycles of latency
		if (r_q.pd_sync[1]) begin
			r_d.low_cnt = '0;
			r_d.pd_filt = 1'h1;
		end else if (r_q.low_cnt != PD_LIMIT) begin
			r_d.low_cnt = r_q.low_cnt + PD_CNT_W'(1);
		end else begin
			r_d.pd_filt = 1'h0;
		end
		r_d.cal = 1'h0;
		unique case (r_q.state)
			PDSS_OFF: begin
				// Waiting for the pin to rise again
				if (r_q.pd_filt) begin
					r_d.state = PDSS_POR;
				end
			end
			PDSS_POR: begin
				// Held here until both monitors report good levels
				if (por_ok) begin
					r_d.cfg.iface_spi = r_q.iface_sync[1];
					r_d.cfg.page = strap_page(overlay_valid,
						r_q.strap_b_sync[1], r_q.strap_a_sync[1]);
					r_d.dev_rst_n = 1'h1;
					r_d = enter_startup(r_d);
				end
			end
			PDSS_START: begin
				// Calibration and PLL start-up interval
				if (r_q.st_cnt == ST_LAST) begin
					r_d.state = PDSS_RUN;
					r_d.run = 1'h1;
				end else begin
					r_d.st_cnt = r_q.st_cnt + STARTUP_CNT_W'(1);
				end
			end
			PDSS_RUN: begin
				// Soft reset restarts calibration, straps are kept
				if (soft_reset) begin
					r_d = enter_startup(r_d);
				end
			end
		endcase
		// Core supply loss falls back to the power-on reset hold; a dip of
		// the pin alone is left to the filter, so short pulses cannot reset
		if (r_q.state != PDSS_OFF && !r_q.okc_sync[1]) begin
			r_d = hold_reset(r_d, PDSS_POR);
		end
		// Power-down overrides everything
		if (!r_q.pd_filt) begin
			r_d = hold_reset(r_d, PDSS_OFF);
		end
		// Serial port only answers outside power-down and reset
		r_d.ser_en = r_d.dev_rst_n && r_q.pd_filt;
	end

	// Power-on reset condition from synchronised monitors
	// Only read while waiting in POR; run-time loss uses the supply alone
	assign por_ok = r_q.okc_sync[1] && r_q.okp_sync[1];

	// State register
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			r_q <= RESET_REGS;
		end else begin
			r_q <= r_d;
		end
	end

	// Outputs straight from flops
	// No output is decoded from state, so none can glitch at a transition
	assign device_reset_n = r_q.dev_rst_n;
	assign serial_enable = r_q.ser_en;
	assign calibrate = r_q.cal;
	assign running = r_q.run;
	assign cfg = r_q.cfg;
endmodule : pdss_top
`default_nettype wire

// ==== shared/pdss_pkg.sv ====
// Package of constants and carrier types for the power-down and strap block
`default_nettype none
package pdss_pkg;
	// Timing: shortest power-down pulse that counts as a hard reset
	localparam int CLK_PERIOD_PS = 8000;
	localparam int MIN_PD_PULSE_NS = 200;
	// Least time rounds up to whole cycles
	localparam int MIN_PD_CYCLES =
		(MIN_PD_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int PD_CNT_W = 6;
	// Default length of the calibration and PLL start-up phase, in cycles
	localparam int STARTUP_CYCLES = 64;
	localparam int STARTUP_CNT_W = 16;
	// Interface select encoding
	localparam logic IFACE_I2C = 1'h0;
	localparam logic IFACE_SPI = 1'h1;
	// Strap page code width and overlay page code
	localparam int PAGE_W = 2;
	localparam logic [2:0] PAGE_OVERLAY = 3'h4;

	typedef enum logic [1:0] {
		PDSS_OFF = 2'h0,
		PDSS_POR = 2'h1,
		PDSS_START = 2'h2,
		PDSS_RUN = 2'h3
	} pdss_state_t;

	// Power-on reset conditions from the analog monitors
	typedef struct packed {
		logic core_supply_ok;
		logic pd_above_vih;
	} pdss_por_t;

	// Start-up configuration caught from the straps
	typedef struct packed {
		logic iface_spi;
		logic [2:0] page;
	} pdss_cfg_t;
endpackage : pdss_pkg
`default_nettype wire

// ==== tb/pdss_props.sv ====
// Checker on the power-down and strap block ports
`timescale 1ns/1ps
`default_nettype none
module pdss_props #(parameter int STARTUP_LEN = 4) (
	input wire logic core_clk, reset_n, power_down_n, soft_reset,
	input wire pdss_pkg::pdss_por_t por_in,
	input wire logic device_reset_n, serial_enable, calibrate, running,
	input wire pdss_pkg::pdss_cfg_t cfg
);
	int low_q, cal_q;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	// Low pin samples and cycles since calibration began
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			low_q <= 0;
			cal_q <= 0;
		end else begin
			low_q <= power_down_n ? 0 : low_q + 1;
			cal_q <= calibrate ? 1 : cal_q + 1;
		end
	end
	a_down_stays_off: assert property (low_q > 30 |->
		!device_reset_n && !serial_enable && !running)
		else $error("active while powered down");
	a_serial_gated: assert property (serial_enable |-> device_reset_n)
		else $error("serial on in reset");
	a_start_calib: assert property ($rose(device_reset_n) |-> calibrate)
		else $error("no calibration at start");
	a_calib_pulse: assert property (calibrate |=> !calibrate)
		else $error("calibration pulse too long");
	a_run_delay: assert property ($rose(running) |->
		cal_q == STARTUP_LEN)
		else $error("start-up length wrong");
	a_cfg_held: assert property (running && $past(running) |->
		$stable(cfg))
		else $error("config moved in run");
	a_por_holds: assert property ((!por_in.core_supply_ok)[*4] |->
		!device_reset_n) else $error("out of reset on low supply");
	a_soft_recal: assert property (running && soft_reset |->
		##[1:3] calibrate) else $error("soft reset skipped calibration");
endmodule : pdss_props
bind pdss_top pdss_props #(.STARTUP_LEN(STARTUP_LEN)) pdss_props_inst (.*);
`default_nettype wire

// ==== tb/pdss_host.sv ====
// Host model driving the power-down pin and supply monitors
`timescale 1ns/1ps
`default_nettype none
module pdss_host (
	input wire logic supplies_ok,
	input wire logic release_req,
	output logic power_down_n,
	output pdss_pkg::pdss_por_t por_in
);
	import pdss_pkg::*;
	// Pin follows the host release request directly; it does not wait for supplies
	assign power_down_n = release_req;
	// Monitors track supply and pin levels
	assign por_in = {supplies_ok, power_down_n};
endmodule : pdss_host
`default_nettype wire

// ==== tb/power_down_and_startup_strap_bench.sv ====
// Self-checking bench for the power-down and strap block
`timescale 1ns/1ps
`default_nettype none
module power_down_and_startup_strap_bench;
	import pdss_pkg::*;
	logic core_clk = 0, reset_n = 0, sup = 1, rel = 0, soft_reset = 0;
	logic interface_select_strap = 0, page_select_strap_a = 0;
	logic page_select_strap_b = 0, overlay_valid = 0, power_down_n;
	logic device_reset_n, serial_enable, calibrate, running;
	pdss_por_t por_in;
	pdss_cfg_t cfg;
	int err_total = 0, cmp_count = 0, seed = 32'h163e, k, i;
	pdss_top #(.STARTUP_LEN(4)) pdss_top_inst (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.power_down_n(power_down_n),
		.por_in(por_in),
		.interface_select_strap(interface_select_strap),
		.page_select_strap_a(page_select_strap_a),
		.page_select_strap_b(page_select_strap_b),
		.overlay_valid(overlay_valid),
		.soft_reset(soft_reset),
		.device_reset_n(device_reset_n),
		.serial_enable(serial_enable),
		.calibrate(calibrate),
		.running(running),
		.cfg(cfg));
	pdss_host pdss_host_inst (.supplies_ok(sup), .release_req(rel),
		.power_down_n(power_down_n), .por_in(por_in));
	initial forever #4 core_clk = ~core_clk;
	// Step edges, then settle inputs just after the last one
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : tick
	task automatic report_and_stop;
		$display("mismatches %0d compares %0d", err_total, cmp_count);
		if (err_total == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : report_and_stop
	task automatic chk(input logic [3:0] g, input logic [3:0] e);
		cmp_count++;
		if (g !== e) begin
			err_total++;
			$display("unexpected at %0t: %h not %h", $time, g, e);
		end
	endtask : chk
	// Bounded wait; a hang ends the run
	task automatic wait_run(input logic w);
		for (i = 0; i < 200 && running !== w; i++)
			tick(1);
		chk({3'h0, running}, {3'h0, w});
		if (running !== w)
			report_and_stop();
	endtask : wait_run
	initial begin
		tick(6);
		reset_n = 1;
		for (k = 0; k < 16; k++) begin
			rel = 0;
			{overlay_valid, interface_select_strap, page_select_strap_b,
				page_select_strap_a} = 4'(k);
			tick(40);
			chk({1'h0, device_reset_n, serial_enable, running}, 4'h0);
			rel = 1;
			wait_run(1);
			chk(cfg, {interface_select_strap,
				overlay_valid ? PAGE_OVERLAY :
				{1'h0, page_select_strap_b, page_select_strap_a}});
			chk({1'h0, device_reset_n, serial_enable, running}, 4'h7);
			// Glitch shorter than the power-down filter window must not reset
			rel = 0;
			tick(5 + ($random(seed) & 15));
			rel = 1;
			tick(10);
			chk({1'h0, device_reset_n, serial_enable, running}, 4'h7);
			soft_reset = 1;
			tick(1);
			soft_reset = 0;
			tick(2);
			chk({1'h0, device_reset_n, serial_enable, running}, 4'h6);
			wait_run(1);
		end
		sup = 0;
		tick(6);
		chk({3'h0, device_reset_n}, 4'h0);
		sup = 1;
		wait_run(1);
		report_and_stop();
	end
endmodule : power_down_and_startup_strap_bench
`default_nettype wire
